// *** sau_line_receiver.sv ***
// Behavioural receiver standing on the far end of the serial line
`timescale 1ns/1ns
module sau_line_receiver (
   // Clock
   input wire logic i_ref_clk,
   // Line and expected framing
   input wire logic i_arm,
   input wire logic i_line,
   input wire logic i_idle_level,
   input wire logic [15:0] i_bit_cycles,
   input wire logic [3:0] i_nbits,
   // Captured frame, first line bit in bit 0
   output logic [15:0] o_frame,
   output logic [7:0] o_count
);
   logic [15:0] shift; // Bits gathered so far
   initial begin
      o_frame = 16'h0000;
      o_count = 8'h00;
   end
   // Waits for a start edge, then samples each bit at its centre
   always begin
      @(posedge i_ref_clk);
      if (i_arm === 1'b1 && i_line !== i_idle_level) begin
         shift = 16'h0000;
         repeat (i_bit_cycles / 2) @(posedge i_ref_clk);
         for (int i = 0; i < i_nbits; i++) begin
            shift[i] = i_line;
            if (i < i_nbits - 1) repeat (i_bit_cycles) @(posedge i_ref_clk);
         end
         o_frame <= shift;
         o_count <= o_count + 8'h01;
      end
   end
endmodule

// *** sau_tx_pkg.sv ***
// Constants, register map and field layouts of the serial transmit channel
// Operation
// R1 - Op clock from prescaler a or b
// R2 - Bit clock is op clock over 2*(div+1)
// R3 - External serial clock at most op/6
// R4 - Stop channels before changing system clock
// R5 - Low data read clears buffer full
// R6 - Ones in flag clear clear errors
// R7 - Even channel transmits, odd receives
// R8 - Frame: start, data, parity, stops
// R9 - Seven or eight data bits
// R10 - Order bit: 0 MSB first, 1 LSB
// R11 - Parity none, zero, even, odd
// R12 - One or two stop bits
// R13 - Optional line inversion, idle level follows; the idle line here shows the preset level, which the inversion does not touch
// R14 - Software keeps divider at two or more
// R15 - Interrupt on transfer end or buffer empty
// R16 - Write while full replaces pending word
// R17 - Change interrupt source before last bit
// R18 - Stop bit clears enable status
// R19 - Preset output level before transmit
// R20 - Transfer status high while word shifts
// R21 - Start bit enables channel
package sau_tx_pkg;
   // Register bus widths
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   // Register indices
   localparam logic [3:0] OFS_PRESCALER_SELECT = 4'h0;
   localparam logic [3:0] OFS_CHANNEL_MODE = 4'h1;
   localparam logic [3:0] OFS_COMM_SETTING = 4'h2;
   localparam logic [3:0] OFS_DATA_REG_LOW = 4'h3;
   localparam logic [3:0] OFS_DATA_REG_HIGH = 4'h4;
   localparam logic [3:0] OFS_CHANNEL_STATUS = 4'h5;
   localparam logic [3:0] OFS_FLAG_CLEAR = 4'h6;
   localparam logic [3:0] OFS_START_TRIGGER = 4'h7;
   localparam logic [3:0] OFS_STOP_TRIGGER = 4'h8;
   localparam logic [3:0] OFS_ENABLE_STATUS = 4'h9;
   localparam logic [3:0] OFS_OUTPUT_LEVEL = 4'ha;
   localparam logic [3:0] OFS_OUTPUT_ENABLE = 4'hb;
   localparam logic [3:0] OFS_OUTPUT_INVERT = 4'hc;
   // Field positions
   localparam int MODE_CLK_SEL_BIT = 15;
   localparam int MODE_IRQ_SRC_BIT = 0;
   localparam int COMM_PARITY_LSB = 8;
   localparam int COMM_ORDER_BIT = 7;
   localparam int COMM_STOP_LSB = 4;
   localparam int COMM_LEN_BIT = 0;
   localparam int STAT_TSF_BIT = 6;
   localparam int STAT_BFF_BIT = 5;
   localparam int STAT_OVR_BIT = 0;
   // Reset values
   localparam logic [7:0] RST_PRESCALER = 8'h00;
   localparam logic [6:0] RST_DIVIDER = 7'h7f;
   localparam logic [1:0] RST_STOP_LEN = 2'h1;
   // Parity and stop codes
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] PAR_ODD = 2'h3;
   localparam logic [1:0] STOP_TWO = 2'h2;
   // Last data index for each length
   localparam logic [2:0] LAST_IDX_7 = 3'h6;
   localparam logic [2:0] LAST_IDX_8 = 3'h7;
   // Frame settings carried as one group
   typedef struct packed {
      logic [1:0] parity;
      logic lsb_first;
      logic [1:0] stop_len;
      logic eight_bit;
   } frame_cfg_t;
   // Transmitter states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_DATA = 3'b010,
      ST_PARITY = 3'b011,
      ST_STOP = 3'b100
   } tx_state_t;
endpackage

// *** sau_uart_tx.sv ***
// Transmit channel of the serial array unit: clocking, framing, registers
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module sau_uart_tx
   import sau_tx_pkg::*;
#(
   parameter int CHANNEL_INDEX = 0
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   // Register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   // Serial line and event
   output logic o_serial_tx_pin,
   output logic o_serial_output_enable,
   output logic o_tx_interrupt
);
   // Only an even channel can be a transmitter
   if (CHANNEL_INDEX % 2 != 0) begin : g_bad_channel // see R7
      $error("transmit channel index must be even");
   end

   // Software visible state
   logic [7:0] prescaler_select_q; // Two 4-bit codes
   logic op_clock_select_q; // Prescaler choice
   logic interrupt_source_sel_q; // 0 end, 1 empty
   frame_cfg_t cfg_q; // Frame shape
   logic [6:0] divider_q; // Bit rate divider
   logic [7:0] buf_q; // Pending transmit word
   logic buffer_full_flag_q; // Pending word valid
   logic overrun_q; // Word overwritten
   logic channel_enable_status_q; // Channel running
   logic serial_output_level_q; // Idle line level
   logic serial_output_enable_q; // Output enable
   logic output_invert_sel_q; // Line inversion
   logic [DATA_W-1:0] rdata_q; // Read answer
   // Transmitter state
   tx_state_t state_q;
   logic [7:0] shift_q; // Word being sent
   logic [2:0] idx_q; // Data bit index
   logic stop_idx_q; // Stop bit index
   logic [7:0] bit_cnt_q; // Op ticks in bit
   logic [14:0] pre_cnt_q; // Free prescaler count
   logic transfer_status_flag_q; // Word in flight
   logic line_q; // Registered line
   logic irq_q; // Interrupt pulse

   // Decoded strobes
   logic wr_hit_low, rd_hit_low, wr_start, wr_stop, wr_clear;
   assign wr_hit_low = i_wr && (i_addr == OFS_DATA_REG_LOW);
   assign rd_hit_low = i_rd && (i_addr == OFS_DATA_REG_LOW);
   assign wr_start = i_wr && (i_addr == OFS_START_TRIGGER) && i_wdata[0];
   assign wr_stop = i_wr && (i_addr == OFS_STOP_TRIGGER) && i_wdata[0];
   assign wr_clear = i_wr && (i_addr == OFS_FLAG_CLEAR);

   // Prescaler ticks: divide by two to the power of the code
   logic [15:0] mask_a, mask_b;
   logic tick_a, tick_b, op_tick;
   assign mask_a = 16'((17'h1 << prescaler_select_q[3:0]) - 17'h1);
   assign mask_b = 16'((17'h1 << prescaler_select_q[7:4]) - 17'h1);
   assign tick_a = (({1'b0, pre_cnt_q} & mask_a) == mask_a); // see R1
   assign tick_b = (({1'b0, pre_cnt_q} & mask_b) == mask_b); // see R1
   assign op_tick = op_clock_select_q ? tick_b : tick_a; // see R1

   // Bit time ends after 2*(div+1) op ticks
   logic bit_end;
   assign bit_end = op_tick && (bit_cnt_q == {divider_q, 1'b1}); // see R2

   // Frame helpers
   logic [2:0] last_idx;
   logic last_stop, data_bit, par_bit, load;
   logic [7:0] word_m;
   assign last_idx = cfg_q.eight_bit ? LAST_IDX_8 : LAST_IDX_7; // see R9
   assign last_stop = (cfg_q.stop_len == STOP_TWO) ? stop_idx_q : 1'b1;
   assign word_m = cfg_q.eight_bit ? shift_q : {1'b0, shift_q[6:0]};
   // Order bit picks which end goes first
   assign data_bit = cfg_q.lsb_first ? shift_q[idx_q]
                                     : shift_q[last_idx - idx_q]; // see R10
   always_comb begin
      unique case (cfg_q.parity)
         PAR_EVEN: par_bit = ^word_m; // see R11
         PAR_ODD: par_bit = ~^word_m; // see R11
         default: par_bit = 1'b0; // see R11
      endcase
   end
   // New word taken when idle, or right at the end of the last stop bit
   assign load = channel_enable_status_q && buffer_full_flag_q &&
                 ((state_q == ST_IDLE) ||
                  (state_q == ST_STOP && bit_end && last_stop));

   // Line level before the output flop
   logic raw_bit, line_d;
   always_comb begin
      unique case (state_q)
         ST_IDLE: raw_bit = 1'b1;
         ST_START: raw_bit = 1'b0;
         ST_DATA: raw_bit = data_bit;
         ST_PARITY: raw_bit = par_bit;
         ST_STOP: raw_bit = 1'b1;
         default: raw_bit = 1'b1;
      endcase
   end
   // Idle line shows the preset level; frames follow the inversion
   assign line_d = (state_q == ST_IDLE) ? serial_output_level_q
                   : (raw_bit ^ output_invert_sel_q); // see R13 R19

   // Free running prescaler count
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pre_cnt_q <= 15'h0000;
      end else begin
         pre_cnt_q <= pre_cnt_q + 15'h0001;
      end
   end

   // Plain configuration registers
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         prescaler_select_q <= RST_PRESCALER;
         op_clock_select_q <= 1'b0;
         interrupt_source_sel_q <= 1'b0;
         cfg_q <= '{parity: PAR_NONE, lsb_first: 1'b0,
                    stop_len: RST_STOP_LEN, eight_bit: 1'b1};
         divider_q <= RST_DIVIDER;
         serial_output_level_q <= 1'b1;
         serial_output_enable_q <= 1'b0;
         output_invert_sel_q <= 1'b0;
      end else if (i_wr) begin
         unique case (i_addr)
            // Clock codes; software stops the unit first
            OFS_PRESCALER_SELECT: prescaler_select_q <= i_wdata[7:0]; // see R4
            OFS_CHANNEL_MODE: begin
               op_clock_select_q <= i_wdata[MODE_CLK_SEL_BIT];
               // May change while running
               interrupt_source_sel_q <= i_wdata[MODE_IRQ_SRC_BIT]; // see R17
            end
            OFS_COMM_SETTING: begin
               cfg_q.parity <= i_wdata[COMM_PARITY_LSB +: 2];
               cfg_q.lsb_first <= i_wdata[COMM_ORDER_BIT];
               cfg_q.stop_len <= i_wdata[COMM_STOP_LSB +: 2];
               cfg_q.eight_bit <= i_wdata[COMM_LEN_BIT];
            end
            // Divider sits in bits seven to one; two or more expected
            OFS_DATA_REG_HIGH: divider_q <= i_wdata[7:1]; // see R2 R14
            OFS_OUTPUT_LEVEL: serial_output_level_q <= i_wdata[0]; // see R19
            OFS_OUTPUT_ENABLE: serial_output_enable_q <= i_wdata[0];
            OFS_OUTPUT_INVERT: output_invert_sel_q <= i_wdata[0]; // see R13
            default: ;
         endcase
      end
   end

   // Channel enable from start and stop triggers
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         channel_enable_status_q <= 1'b0;
      end else if (wr_stop) begin
         channel_enable_status_q <= 1'b0; // see R18
      end else if (wr_start) begin
         channel_enable_status_q <= 1'b1; // see R21
      end
   end

   // Pending word and its full flag; a write beats a load
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         buf_q <= 8'h00;
         buffer_full_flag_q <= 1'b0;
      end else if (wr_hit_low) begin
         buf_q <= i_wdata[7:0]; // see R16
         buffer_full_flag_q <= 1'b1;
      end else if (rd_hit_low || load) begin
         buffer_full_flag_q <= 1'b0; // see R5
      end
   end

   // Overrun flag; a new overwrite beats the clear
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         overrun_q <= 1'b0;
      end else if (wr_hit_low && buffer_full_flag_q) begin
         overrun_q <= 1'b1;
      end else if (wr_clear && i_wdata[STAT_OVR_BIT]) begin
         overrun_q <= 1'b0; // see R6
      end
   end

   // Bit timing counter, restarted at every bit boundary
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bit_cnt_q <= 8'h00;
      end else if (state_q == ST_IDLE || bit_end) begin
         bit_cnt_q <= 8'h00; // see R2
      end else if (op_tick) begin
         bit_cnt_q <= bit_cnt_q + 8'h01;
      end
   end

   // Frame sequencer: start, data, parity, stop
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= ST_IDLE;
         shift_q <= 8'h00;
         idx_q <= 3'h0;
         stop_idx_q <= 1'b0;
      end else if (wr_stop) begin
         state_q <= ST_IDLE; // see R18
      end else if (load) begin
         state_q <= ST_START; // see R8 R21
         shift_q <= buf_q;
         idx_q <= 3'h0;
         stop_idx_q <= 1'b0;
      end else if (bit_end) begin
         unique case (state_q)
            ST_START: state_q <= ST_DATA; // see R8
            ST_DATA: begin
               // Length decides the last index
               if (idx_q == last_idx) begin // see R9
                  state_q <= (cfg_q.parity == PAR_NONE) ? ST_STOP
                                                        : ST_PARITY;
               end else begin
                  idx_q <= idx_q + 3'h1;
               end
            end
            ST_PARITY: state_q <= ST_STOP; // see R11
            ST_STOP: begin
               // One or two stop bits
               if (last_stop) begin // see R12
                  state_q <= ST_IDLE;
               end else begin
                  stop_idx_q <= 1'b1;
               end
            end
            ST_IDLE: ;
         endcase
      end
   end

   // Transfer status follows the word in flight
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         transfer_status_flag_q <= 1'b0;
      end else if (wr_stop) begin
         transfer_status_flag_q <= 1'b0;
      end else if (load) begin
         transfer_status_flag_q <= 1'b1; // see R20
      end else if (state_q == ST_STOP && bit_end && last_stop) begin
         transfer_status_flag_q <= 1'b0; // see R20
      end
   end

   // Interrupt pulse: buffer empty on load, or transfer end
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_q <= 1'b0;
      end else if (interrupt_source_sel_q) begin
         irq_q <= load; // see R15
      end else begin
         irq_q <= (state_q == ST_STOP) && bit_end && last_stop; // see R15
      end
   end

   // Line output flop
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         line_q <= 1'b1;
      end else begin
         line_q <= line_d;
      end
   end

   // Read answer one cycle after the strobe
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_q <= 16'h0000;
      end else if (i_rd) begin
         unique case (i_addr)
            OFS_PRESCALER_SELECT: rdata_q <= {8'h00, prescaler_select_q};
            OFS_CHANNEL_MODE: rdata_q <= {op_clock_select_q, 14'h0000,
                                          interrupt_source_sel_q};
            OFS_COMM_SETTING: rdata_q <= {6'h00, cfg_q.parity,
                                          cfg_q.lsb_first, 1'b0,
                                          cfg_q.stop_len, 3'h0,
                                          cfg_q.eight_bit};
            OFS_DATA_REG_LOW: rdata_q <= {8'h00, buf_q};
            OFS_DATA_REG_HIGH: rdata_q <= {8'h00, divider_q, 1'b0};
            OFS_CHANNEL_STATUS: rdata_q <= {9'h000, transfer_status_flag_q,
                                            buffer_full_flag_q, 4'h0,
                                            overrun_q};
            OFS_ENABLE_STATUS: rdata_q <= {15'h0000,
                                           channel_enable_status_q};
            OFS_OUTPUT_LEVEL: rdata_q <= {15'h0000, serial_output_level_q};
            OFS_OUTPUT_ENABLE: rdata_q <= {15'h0000, serial_output_enable_q};
            OFS_OUTPUT_INVERT: rdata_q <= {15'h0000, output_invert_sel_q};
            default: rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   // Outputs straight from flops
   assign o_rdata = rdata_q;
   assign o_serial_tx_pin = line_q;
   assign o_serial_output_enable = serial_output_enable_q;
   assign o_tx_interrupt = irq_q;

   // Checks on the logic above
   a_busy_tracks_state: assert property ( // see R20
      @(posedge i_ref_clk) disable iff (!i_resetn)
      transfer_status_flag_q == (state_q != ST_IDLE))
      else $error("transfer status disagrees with state");
   a_read_clears_full: assert property ( // see R5
      @(posedge i_ref_clk) disable iff (!i_resetn)
      rd_hit_low |=> !buffer_full_flag_q)
      else $error("buffer full survived a data read");
   a_clear_error_flag: assert property ( // see R6
      @(posedge i_ref_clk) disable iff (!i_resetn)
      wr_clear && i_wdata[STAT_OVR_BIT] |=> !overrun_q)
      else $error("error flag not cleared");
   a_start_enables: assert property ( // see R21
      @(posedge i_ref_clk) disable iff (!i_resetn)
      wr_start |=> channel_enable_status_q)
      else $error("start did not enable channel");
   a_stop_disables: assert property ( // see R18
      @(posedge i_ref_clk) disable iff (!i_resetn)
      wr_stop |=> !channel_enable_status_q && state_q == ST_IDLE)
      else $error("stop did not halt channel");
   a_overwrite_word: assert property ( // see R16
      @(posedge i_ref_clk) disable iff (!i_resetn)
      wr_hit_low && buffer_full_flag_q |=>
      buf_q == $past(i_wdata[7:0]) && overrun_q)
      else $error("pending word not replaced");
   a_start_level: assert property ( // see R8
      @(posedge i_ref_clk) disable iff (!i_resetn)
      state_q == ST_START |=> o_serial_tx_pin == $past(output_invert_sel_q))
      else $error("start bit level wrong");
   a_parity_bit: assert property ( // see R11
      @(posedge i_ref_clk) disable iff (!i_resetn)
      state_q == ST_PARITY && cfg_q.parity == PAR_ODD |->
      ^{word_m, raw_bit})
      else $error("odd parity bit wrong");
   a_op_clock_fast: assert property ( // see R1
      @(posedge i_ref_clk) disable iff (!i_resetn)
      prescaler_select_q[3:0] == 4'h0 && !op_clock_select_q |-> op_tick)
      else $error("undivided op clock missed a tick");
   a_irq_transfer_end: assert property ( // see R15
      @(posedge i_ref_clk) disable iff (!i_resetn)
      !interrupt_source_sel_q && $fell(transfer_status_flag_q) &&
      !$past(wr_stop) |-> o_tx_interrupt)
      else $error("transfer end interrupt missing");
endmodule

// *** sau_uart_tx_bench.sv ***
// Self-checking bench of the serial transmit channel
`timescale 1ns/1ns
module sau_uart_tx_bench
   import sau_tx_pkg::*;
;
   logic i_ref_clk, i_resetn, i_wr, i_rd;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata, o_rdata, got;
   logic o_serial_tx_pin, o_serial_output_enable, o_tx_interrupt;
   logic line, idle, arm; // Line wire and receiver controls
   logic [15:0] bitc, rx_frame, exp_a, exp_b;
   logic [3:0] nbits, nb;
   logic [7:0] rx_count, c0, d0, d1;
   logic [1:0] par, ca, cb, dl; // Frame and clock settings
   logic lsb, two, eight, inv, sel, mode;
   logic [6:0] div;
   int bad_count, checked, seed, r;
   int irq_n = 0;
   int irq0;
   // Reset read-back table
   localparam logic [3:0] RA [10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h9,
      4'ha, 4'hb, 4'hc, 4'hf};
   localparam logic [15:0] RV [10] = '{16'h0000, 16'h0000, 16'h0011,
      16'h00fe, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
   // Design and far-end receiver
   sau_uart_tx i_sau_uart_tx (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .o_serial_tx_pin(o_serial_tx_pin),
      .o_serial_output_enable(o_serial_output_enable),
      .o_tx_interrupt(o_tx_interrupt));
   // Released line floats to its pull-up
   assign line = (o_serial_output_enable === 1'b1) ? o_serial_tx_pin : 1'b1;
   sau_line_receiver i_sau_line_receiver (.i_ref_clk(i_ref_clk),
      .i_arm(arm), .i_line(line), .i_idle_level(idle), .i_bit_cycles(bitc),
      .i_nbits(nbits), .o_frame(rx_frame), .o_count(rx_count));
   // Clock
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   // Interrupt pulse counter
   always @(posedge i_ref_clk) begin
      if (o_tx_interrupt === 1'b1) irq_n <= irq_n + 1;
   end
   // Register write, one strobe cycle
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   // Register read, data taken in the following cycle
   task automatic rd(input logic [3:0] a);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 got = o_rdata;
   endtask
   // Register value comparison
   task automatic chk_value(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Line frame comparison
   task automatic chk_frame(input logic [15:0] g, input logic [15:0] e);
      chk_value(g, e);
   endtask
   // Bounded wait for the receiver count
   task automatic wait_rx(input logic [7:0] n);
      for (int i = 0; i < 4000 && rx_count !== n; i++) @(posedge i_ref_clk);
   endtask
   // Expected line levels of one frame, and its bit count
   function automatic logic [15:0] frame_bits(input logic [7:0] d,
      output logic [3:0] n);
      int w, k;
      logic p;
      logic [15:0] f;
      w = eight ? 8 : 7;
      f = 16'h0000;
      k = 1;
      p = ^(d & (eight ? 8'hff : 8'h7f));
      for (int i = 0; i < w; i++) begin
         f[k] = lsb ? d[i] : d[w-1-i];
         k++;
      end
      if (par != PAR_NONE) begin
         f[k] = (par == PAR_EVEN) ? p : (par == PAR_ODD) ? ~p : 1'b0;
         k++;
      end
      f[k] = 1'b1;
      k = two ? k + 2 : k + 1;
      if (two) f[k-1] = 1'b1;
      n = 4'(k);
      return f ^ ({16{inv}} & 16'((1 << k) - 1));
   endfunction
   // Verdict and end of run
   task automatic final_report;
      if (bad_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #900000;
      bad_count++;
      final_report();
   end
   // Main sequence
   initial begin
      seed = 23;
      bad_count = 0;
      checked = 0;
      {i_resetn, i_wr, i_rd, i_addr, i_wdata, arm} = '0;
      {idle, bitc, nbits} = {1'b1, 16'd6, 4'd10};
      repeat (3) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      for (int k = 0; k < 10; k++) begin
         rd(RA[k]);
         chk_value(got, RV[k]);
      end
      wr(OFS_OUTPUT_ENABLE, 16'h0001);
      for (int k = 0; k < 12; k++) begin
         r = $random(seed);
         {cb, ca, mode, dl, sel, inv, eight, two, lsb, par} = r[13:0];
         div = 7'(dl) + 7'd2;
         arm <= 1'b0;
         // Channel halted before its clock settings change
         wr(OFS_STOP_TRIGGER, 16'h0001);
         wr(OFS_PRESCALER_SELECT, {10'h000, cb, 2'b00, ca});
         wr(OFS_CHANNEL_MODE, {sel, 14'h0000, mode});
         wr(OFS_COMM_SETTING, {6'h00, par, lsb, 1'b0, two, ~two, 3'h0, eight});
         wr(OFS_DATA_REG_HIGH, {8'h00, div, 1'b0});
         wr(OFS_OUTPUT_INVERT, {15'h0000, inv});
         wr(OFS_OUTPUT_LEVEL, {15'h0000, ~inv});
         wr(OFS_START_TRIGGER, 16'h0001);
         d0 = r[23:16];
         d1 = r[31:24];
         exp_a = frame_bits(d0, nb);
         exp_b = frame_bits(d1, nb);
         repeat (2) @(posedge i_ref_clk);
         idle <= ~inv;
         nbits <= nb;
         bitc <= 16'(2 * (div + 1)) << (sel ? cb : ca);
         arm <= 1'b1;
         irq0 = irq_n;
         c0 = rx_count;
         wr(OFS_DATA_REG_LOW, {8'h00, d0});
         repeat (3) @(posedge i_ref_clk);
         rd(OFS_CHANNEL_STATUS);
         chk_value(got, 16'h0040);
         // Empty-buffer mode has pulsed once by now, end mode not yet
         chk_value(16'(irq_n - irq0), {15'h0000, mode});
         wr(OFS_DATA_REG_LOW, {8'h00, d1});
         wait_rx(c0 + 8'h01);
         chk_frame(rx_frame, exp_a);
         wait_rx(c0 + 8'h02);
         chk_frame(rx_frame, exp_b);
         for (int w = 0; w < 500; w++) begin
            rd(OFS_CHANNEL_STATUS);
            if (got[STAT_TSF_BIT] === 1'b0) break;
         end
         repeat (3) @(posedge i_ref_clk);
         chk_value(16'(irq_n - irq0), 16'h0002);
      end
      c0 = rx_count;
      wr(OFS_STOP_TRIGGER, 16'h0001);
      rd(OFS_ENABLE_STATUS);
      chk_value(got, 16'h0000);
      wr(OFS_DATA_REG_LOW, 16'h005a);
      wr(OFS_DATA_REG_LOW, 16'h00a5);
      rd(OFS_CHANNEL_STATUS);
      chk_value(got, 16'h0021);
      rd(OFS_DATA_REG_LOW);
      chk_value(got, 16'h00a5);
      rd(OFS_CHANNEL_STATUS);
      chk_value(got, 16'h0001);
      wr(OFS_FLAG_CLEAR, 16'h0001);
      rd(OFS_CHANNEL_STATUS);
      chk_value(got, 16'h0000);
      chk_value({8'h00, rx_count}, {8'h00, c0});
      wr(OFS_START_TRIGGER, 16'h0001);
      rd(OFS_ENABLE_STATUS);
      chk_value(got, 16'h0001);
      wr(4'hf, 16'hffff);
      rd(4'hf);
      chk_value(got, 16'h0000);
      final_report();
   end
endmodule
